// ===== hw/tslnr_params.svh
/*
 * constants of the limit / nonvolatile register bank: offsets, field
 * positions, reset values and timing figures.
 * assumes: included by its bare name from the package and design files.
 */
`ifndef TSLNR_PARAMS_SVH
`define TSLNR_PARAMS_SVH

`define TSLNR_ADDR_W      5
`define TSLNR_DATA_W      16
`define TSLNR_VAL_W       14
// register offsets
`define TSLNR_OFS_TEMP    5'h00
`define TSLNR_OFS_CFG     5'h01
`define TSLNR_OFS_UTH1    5'h02
`define TSLNR_OFS_LTH1    5'h03
`define TSLNR_OFS_UTH2    5'h04
`define TSLNR_OFS_LTH2    5'h05
`define TSLNR_OFS_NVM_LO  5'h06
`define TSLNR_OFS_NVM_HI  5'h0d
`define TSLNR_OFS_DIE     5'h0f
`define TSLNR_OFS_STAT    5'h10
`define TSLNR_OFS_CLR     5'h11
`define TSLNR_OFS_IEN     5'h12
// reset values
`define TSLNR_UTH_RST     16'h7ffc
`define TSLNR_LTH_RST     16'h8000
`define TSLNR_NVM_RST     16'h0000
`define TSLNR_RATE_RST    3'h5
// arbitrary neutral identification value
`define TSLNR_SILICON_IDENTITY      16'h0a5c
// field positions
`define TSLNR_LIM_LSB     2
`define TSLNR_UNLOCK_BIT  0
`define TSLNR_RATE_HI     15
`define TSLNR_RATE_LO     13
`define TSLNR_SEL1_BIT    12
`define TSLNR_SEL2_BIT    11
`define TSLNR_FLAG_HI     7
`define TSLNR_FLAG_LO     4
// interrupt events
`define TSLNR_EV_CONV     0
`define TSLNR_EV_AL1      1
`define TSLNR_EV_AL2      2
`define TSLNR_EV_NVM      3
`define TSLNR_EV_N        4
// timing
`define TSLNR_CLK_HZ      200000000
`define TSLNR_MS_PER_S    1000
`define TSLNR_PER_0_MS    15
`define TSLNR_PER_1_MS    50
`define TSLNR_PER_2_MS    100
`define TSLNR_PER_3_MS    250
`define TSLNR_PER_4_MS    500
`define TSLNR_PER_5_MS    1000
`define TSLNR_PER_6_MS    4000
`define TSLNR_PER_7_MS    16000
`define TSLNR_MS_W        14
`define TSLNR_NVM_DEPTH   8

`endif

// ===== hw/tslnr_pkg.sv
/*
 * types of the limit / nonvolatile register bank.
 * assumes: tslnr_params.svh on the include path.
 */
`include "tslnr_params.svh"

package tslnr_pkg;
    typedef logic [`TSLNR_ADDR_W-1:0] tslnr_addr_t;
    typedef logic [`TSLNR_DATA_W-1:0] tslnr_word_t;
    typedef logic [`TSLNR_VAL_W-1:0]  tslnr_val_t;
    typedef logic [`TSLNR_EV_N-1:0]   tslnr_ev_t;
    typedef logic [`TSLNR_MS_W-1:0]   tslnr_ms_t;
    typedef enum logic [2:0] {
        TSLNR_RATE_15MS  = 3'h0,
        TSLNR_RATE_50MS  = 3'h1,
        TSLNR_RATE_100MS = 3'h2,
        TSLNR_RATE_250MS = 3'h3,
        TSLNR_RATE_500MS = 3'h4,
        TSLNR_RATE_1S    = 3'h5,
        TSLNR_RATE_4S    = 3'h6,
        TSLNR_RATE_16S   = 3'h7
    } tslnr_rate_t;
endpackage : tslnr_pkg

// ===== hw/tslnr_mem_if.sv
/*
 * carrier between the register bank and its user word store.
 * assumes: one clock domain; the store registers its read data.
 */
`timescale 1ns/1ps
`default_nettype none

interface tslnr_mem_if;
    import tslnr_pkg::*;
    logic        wr_en;
    logic [2:0]  addr;
    tslnr_word_t wdata;
    tslnr_word_t rdata;
    modport ctrl  (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : tslnr_mem_if

`default_nettype wire

// ===== hw/tslnr_nvm_mem.sv
/*
 * eight-word user store; read data come from a register loaded every
 * cycle from the presented address.
 * assumes: writes are already qualified by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tslnr_params.svh"

module tslnr_nvm_mem #(
    parameter int DEPTH = `TSLNR_NVM_DEPTH
) (
    input  wire logic      clk_sys,
    input  wire logic      reset,
    tslnr_mem_if.store     mem
);
    import tslnr_pkg::*;

    tslnr_word_t word_reg [DEPTH];

    // the carrier's address is three bits wide
    if (DEPTH != `TSLNR_NVM_DEPTH) begin : g_bad_depth
        $error("tslnr_nvm_mem: depth must match the address field");
    end

    // erased state reads as zero
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                word_reg[i] <= `TSLNR_NVM_RST;
            end else if (mem.wr_en && (mem.addr == 3'(i))) begin
                word_reg[i] <= mem.wdata;
            end
        end
    end

    // registered read port
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem.rdata <= `TSLNR_NVM_RST;
        end else begin
            mem.rdata <= word_reg[mem.addr];
        end
    end
endmodule : tslnr_nvm_mem

`default_nettype wire

// ===== hw/tslnr_top.sv
/*
 * register bank of a chained temperature sensor: conversion pacing,
 * two limit pairs with window/threshold flags, user nonvolatile words,
 * identification register, interrupt status/clear/enable.
 * assumes: a conversion engine on clk_sys returns a 14-bit result with a
 * one-cycle temp_valid pulse after each conv_start; the serial front end
 * drives the plain register port.
 */
// The implementer's own choice: the plain strobed port.
// Summary of operation
// R1 - rate field 0..7 selects 15,50,100,250,500 ms,1,4,16 s; 1 s default
// R2 - upper threshold one at 2h, bits 15:2, reset 7ffch, low bits zero
// R3 - lower threshold one at 3h, bits 15:2, reset 8000h, low bits zero
// R4 - upper threshold two at 4h, bits 15:2, reset 7ffch, low bits zero
// R5 - lower threshold two at 5h, bits 15:2, reset 8000h, low bits zero
// R6 - eight 16-bit user words at 6h..dh, reading zero when erased
// R7 - user words accept writes only while the unlock bit is one
// R8 - user word writes while locked are discarded, word unchanged
// R9 - identification register at fh returns a fixed code
// R10 - identification register is read-only, writes do nothing
// R11 - window mode sets high/low flags; configuration read clears them
// R12 - threshold mode: high set above, cleared below low; low flag zero
// R13 - compare each result signed against limits once per conversion
// R14 - next conversion one period after previous start; new rate next period
`timescale 1ns/1ps
`default_nettype none
`include "tslnr_params.svh"

module tslnr_top #(
    parameter int CYC_PER_MS = `TSLNR_CLK_HZ / `TSLNR_MS_PER_S
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire tslnr_pkg::tslnr_addr_t reg_addr,
    input  wire tslnr_pkg::tslnr_word_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    input  wire tslnr_pkg::tslnr_val_t  temp_result,
    input  wire logic               temp_valid,
    output logic                    conv_start,
    output logic                    irq
);
    import tslnr_pkg::*;

    localparam int CNT_W = $clog2(CYC_PER_MS + 1);

    if (CYC_PER_MS < 1) begin : g_bad_cyc
        $error("tslnr_top: CYC_PER_MS must be at least one");
    end

    tslnr_mem_if mem_bus ();

    // ---------------- address decode ----------------
    wire hit_temp = (reg_addr == `TSLNR_OFS_TEMP);
    wire hit_cfg  = (reg_addr == `TSLNR_OFS_CFG);
    wire hit_die  = (reg_addr == `TSLNR_OFS_DIE);
    wire hit_stat = (reg_addr == `TSLNR_OFS_STAT);
    wire hit_clr  = (reg_addr == `TSLNR_OFS_CLR);
    wire hit_ien  = (reg_addr == `TSLNR_OFS_IEN);
    wire hit_nvm  = (reg_addr >= `TSLNR_OFS_NVM_LO) && (reg_addr <= `TSLNR_OFS_NVM_HI); // R6
    wire [1:0] hit_uth;
    wire [1:0] hit_lth;
    assign hit_uth[0] = (reg_addr == `TSLNR_OFS_UTH1); // R2
    assign hit_lth[0] = (reg_addr == `TSLNR_OFS_LTH1); // R3
    assign hit_uth[1] = (reg_addr == `TSLNR_OFS_UTH2); // R4
    assign hit_lth[1] = (reg_addr == `TSLNR_OFS_LTH2); // R5

    wire wr_temp = reg_wr && hit_temp;
    wire wr_cfg  = reg_wr && hit_cfg;
    wire rd_cfg  = reg_rd && hit_cfg;
    wire wr_nvm  = reg_wr && hit_nvm;

    // ---------------- control registers ----------------
    logic        unlock_reg;
    tslnr_rate_t rate_reg;
    logic [1:0]  sel_reg;       // 0 window, 1 threshold, per alert function
    tslnr_val_t  temp_reg;

    // unlock bit lives in the temperature register, result bits read-only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            unlock_reg <= 1'b0;
        end else if (wr_temp) begin
            unlock_reg <= reg_wdata[`TSLNR_UNLOCK_BIT]; // R7
        end
    end

    // configuration: rate field and mode selects
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rate_reg <= tslnr_rate_t'(`TSLNR_RATE_RST); // R1
            sel_reg  <= 2'h0;
        end else if (wr_cfg) begin
            rate_reg <= tslnr_rate_t'(reg_wdata[`TSLNR_RATE_HI:`TSLNR_RATE_LO]);
            sel_reg  <= {reg_wdata[`TSLNR_SEL2_BIT], reg_wdata[`TSLNR_SEL1_BIT]};
        end
    end

    // last completed result
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            temp_reg <= '0;
        end else if (temp_valid) begin
            temp_reg <= temp_result;
        end
    end

    // ---------------- conversion pacing ----------------
    logic [CNT_W-1:0] cyc_cnt_reg;
    tslnr_ms_t        ms_cnt_reg;
    tslnr_rate_t      rate_act_reg;   // rate latched at conversion start
    tslnr_ms_t        period_ms;

    // rate decode into milliseconds
    always_comb begin
        case (rate_act_reg)
            TSLNR_RATE_15MS:  period_ms = tslnr_ms_t'(`TSLNR_PER_0_MS); // R1
            TSLNR_RATE_50MS:  period_ms = tslnr_ms_t'(`TSLNR_PER_1_MS);
            TSLNR_RATE_100MS: period_ms = tslnr_ms_t'(`TSLNR_PER_2_MS);
            TSLNR_RATE_250MS: period_ms = tslnr_ms_t'(`TSLNR_PER_3_MS);
            TSLNR_RATE_500MS: period_ms = tslnr_ms_t'(`TSLNR_PER_4_MS);
            TSLNR_RATE_1S:    period_ms = tslnr_ms_t'(`TSLNR_PER_5_MS);
            TSLNR_RATE_4S:    period_ms = tslnr_ms_t'(`TSLNR_PER_6_MS);
            TSLNR_RATE_16S:   period_ms = tslnr_ms_t'(`TSLNR_PER_7_MS);
            default:          period_ms = tslnr_ms_t'(`TSLNR_PER_5_MS);
        endcase
    end

    wire ms_tick   = (cyc_cnt_reg == CNT_W'(CYC_PER_MS - 1));
    wire period_up = ms_tick && (ms_cnt_reg == period_ms - tslnr_ms_t'(1)); // R14

    // millisecond enable divider
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cyc_cnt_reg <= '0;
        end else if (ms_tick) begin
            cyc_cnt_reg <= '0;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + CNT_W'(1);
        end
    end

    // period counter; a rate change waits for the running period to end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ms_cnt_reg   <= '0;
            rate_act_reg <= tslnr_rate_t'(`TSLNR_RATE_RST);
            conv_start   <= 1'b0;
        end else begin
            conv_start <= period_up; // R14
            if (period_up) begin
                ms_cnt_reg   <= '0;
                rate_act_reg <= rate_reg; // R14
            end else if (ms_tick) begin
                ms_cnt_reg <= ms_cnt_reg + tslnr_ms_t'(1);
            end
        end
    end

    // ---------------- limits and flags ----------------
    tslnr_val_t upper_val_reg [2];
    tslnr_val_t lower_val_reg [2];
    logic [1:0] over_upper_flag;
    logic [1:0] under_lower_flag;
    logic [1:0] flag_rise;

    for (genvar g = 0; g < 2; g++) begin : g_alert
        // signed compare, same 14-bit format as the limits
        wire over  = $signed(temp_result) > $signed(upper_val_reg[g]); // R13
        wire under = $signed(temp_result) < $signed(lower_val_reg[g]); // R13
        wire thr   = sel_reg[g];
        logic hi_next;
        logic lo_next;

        // threshold: hysteresis, no read clear; window: sticky, read clears
        always_comb begin
            hi_next = over_upper_flag[g];
            lo_next = under_lower_flag[g];
            if (thr) begin
                lo_next = 1'b0; // R12
                if (temp_valid && over) begin
                    hi_next = 1'b1; // R12
                end else if (temp_valid && under) begin
                    hi_next = 1'b0; // R12
                end
            end else begin
                // a compare in the read cycle still sets the flag
                if (rd_cfg) begin
                    hi_next = 1'b0; // R11
                    lo_next = 1'b0; // R11
                end
                if (temp_valid && over) begin
                    hi_next = 1'b1; // R11
                end
                if (temp_valid && under) begin
                    lo_next = 1'b1; // R11
                end
            end
        end

        assign flag_rise[g] = (hi_next & ~over_upper_flag[g]) | (lo_next & ~under_lower_flag[g]);

        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                over_upper_flag[g]  <= 1'b0;
                under_lower_flag[g] <= 1'b0;
            end else begin
                over_upper_flag[g]  <= hi_next;
                under_lower_flag[g] <= lo_next;
            end
        end

        // limit fields, two low bits are not stored
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                upper_val_reg[g] <= tslnr_val_t'(`TSLNR_UTH_RST >> `TSLNR_LIM_LSB); // R2
                lower_val_reg[g] <= tslnr_val_t'(`TSLNR_LTH_RST >> `TSLNR_LIM_LSB); // R3
            end else begin
                if (reg_wr && hit_uth[g]) begin
                    upper_val_reg[g] <= reg_wdata[`TSLNR_DATA_W-1:`TSLNR_LIM_LSB]; // R4
                end
                if (reg_wr && hit_lth[g]) begin
                    lower_val_reg[g] <= reg_wdata[`TSLNR_DATA_W-1:`TSLNR_LIM_LSB]; // R5
                end
            end
        end
    end

    // ---------------- user words ----------------
    wire nvm_refused = wr_nvm && !unlock_reg;

    // locked writes never reach the store
    assign mem_bus.wr_en = wr_nvm && unlock_reg; // R7 R8
    assign mem_bus.addr  = 3'(reg_addr - `TSLNR_OFS_NVM_LO);
    assign mem_bus.wdata = reg_wdata;

    tslnr_nvm_mem #(
        .DEPTH (`TSLNR_NVM_DEPTH)
    ) u_nvm (
        .clk_sys (clk_sys),
        .reset   (reset),
        .mem     (mem_bus.store)
    );

    // ---------------- interrupts ----------------
    tslnr_ev_t status_reg;
    tslnr_ev_t ien_reg;
    tslnr_ev_t ev_set;
    wire       wr_clr = reg_wr && hit_clr;

    assign ev_set[`TSLNR_EV_CONV] = temp_valid;
    assign ev_set[`TSLNR_EV_AL1]  = flag_rise[0];
    assign ev_set[`TSLNR_EV_AL2]  = flag_rise[1];
    assign ev_set[`TSLNR_EV_NVM]  = nvm_refused;

    // set beats a clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            status_reg <= '0;
            ien_reg    <= '0;
            irq        <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~(wr_clr ? reg_wdata[`TSLNR_EV_N-1:0] : '0)) | ev_set;
            if (reg_wr && hit_ien) begin
                ien_reg <= reg_wdata[`TSLNR_EV_N-1:0];
            end
            irq <= |(status_reg & ien_reg);
        end
    end

    // ---------------- read path ----------------
    tslnr_word_t cfg_view;
    tslnr_word_t rd_mux;
    logic        rd_nvm_reg;
    tslnr_word_t rdata_reg;

    // flags of a threshold-mode function read zero in the low position
    assign cfg_view = {rate_reg, sel_reg[0], sel_reg[1], 3'h0,
                       over_upper_flag[0], under_lower_flag[0] & ~sel_reg[0],
                       over_upper_flag[1], under_lower_flag[1] & ~sel_reg[1], 4'h0};

    assign rd_mux = hit_temp   ? {temp_reg, 1'b0, unlock_reg} :
                    hit_cfg    ? cfg_view :
                    hit_uth[0] ? {upper_val_reg[0], 2'h0} : // R2
                    hit_lth[0] ? {lower_val_reg[0], 2'h0} : // R3
                    hit_uth[1] ? {upper_val_reg[1], 2'h0} : // R4
                    hit_lth[1] ? {lower_val_reg[1], 2'h0} : // R5
                    hit_die    ? `TSLNR_SILICON_IDENTITY :            // R9 R10
                    hit_stat   ? {12'h000, status_reg} :
                    hit_ien    ? {12'h000, ien_reg} :
                    16'h0000;

    // data register, zero outside the answer cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_reg  <= '0;
            rd_nvm_reg <= 1'b0;
        end else begin
            rdata_reg  <= reg_rd ? rd_mux : '0;
            rd_nvm_reg <= reg_rd && hit_nvm;
        end
    end

    // store answers from its own output register
    assign reg_rdata = rd_nvm_reg ? mem_bus.rdata : rdata_reg; // R6
endmodule : tslnr_top

`default_nettype wire

// ===== bench/tslnr_top_monitor.sv
/*
 * concurrent checks on the ports of tslnr_top, attached by bind.
 * assumes: one clock domain, reset asynchronous and active high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tslnr_params.svh"

module tslnr_top_monitor #(
    parameter int CYC_PER_MS = 200000
) (
    input wire logic                   clk_sys,
    input wire logic                   reset,
    input wire tslnr_pkg::tslnr_addr_t reg_addr,
    input wire tslnr_pkg::tslnr_word_t reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    input wire tslnr_pkg::tslnr_val_t  temp_result,
    input wire logic                   temp_valid,
    input wire logic                   conv_start,
    input wire logic                   irq
);
    import tslnr_pkg::*;
    localparam int MIN_GAP = 15 * CYC_PER_MS;
    // wide enough for the longest period at the full clock rate
    localparam longint MAX_GAP = longint'(16000) * CYC_PER_MS;
    longint gap_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // cycles since the last start; saturates so a stuck pacer still fails
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gap_reg <= 0;
        end else if (conv_start) begin
            gap_reg <= 1;
        end else if (gap_reg <= MAX_GAP) begin
            gap_reg <= gap_reg + 1;
        end
    end

    // read port, start pacing and interrupt causes
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_id_fixed: assert property (reg_rd && reg_addr == 5'h0f |=> reg_rdata == `TSLNR_SILICON_IDENTITY)
        else $error("identification read wrong");
    a_limit_lsbs: assert property (reg_rd && reg_addr inside {[5'h02:5'h05]} |=>
        reg_rdata[1:0] == 2'b00) else $error("limit low bits not zero");
    a_unmapped_zero: assert property (reg_rd && reg_addr inside {5'h0e, 5'h11,
        [5'h13:5'h1f]} |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    a_start_gap: assert property (conv_start |-> gap_reg >= MIN_GAP)
        else $error("starts closer than the shortest period");
    a_start_late: assert property (gap_reg <= MAX_GAP)
        else $error("no start within the longest period");
    a_irq_cause: assert property ($rose(irq) |-> $past(temp_valid, 2) || $past(reg_wr, 2))
        else $error("interrupt rose without a cause");
    a_irq_clear: assert property ($fell(irq) |-> $past(reg_wr, 2))
        else $error("interrupt fell without a write");

    c_start: cover property (conv_start);
    c_irq: cover property ($rose(irq));
    c_user_read: cover property (reg_rd && reg_addr == 5'h06);
endmodule : tslnr_top_monitor

bind tslnr_top tslnr_top_monitor #(.CYC_PER_MS(CYC_PER_MS)) i_tslnr_top_monitor (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_result(temp_result),
    .temp_valid(temp_valid), .conv_start(conv_start), .irq(irq));

`default_nettype wire

// ===== bench/tslnr_conv_model.sv
/*
 * behavioural conversion engine facing tslnr_top: answers each start
 * with one result pulse LAT+1 cycles after the start pulse.
 * assumes: same clock as the bank; the bench chooses the next result.
 */
`timescale 1ns/1ps
`default_nettype none

module tslnr_conv_model #(
    parameter int LAT = 3
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  conv_start,
    input  wire tslnr_pkg::tslnr_val_t next_res,
    output logic                       temp_valid,
    output tslnr_pkg::tslnr_val_t      temp_result
);
    import tslnr_pkg::*;
    int cnt_reg;

    // count down from each start; result toggles outside the pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_reg <= 0;
            temp_valid <= 1'b0;
            temp_result <= '0;
        end else begin
            cnt_reg <= conv_start ? LAT : (cnt_reg > 0 ? cnt_reg - 1 : 0);
            temp_valid <= (cnt_reg == 1);
            temp_result <= (cnt_reg == 1) ? next_res : ~temp_result; // never held
        end
    end
endmodule : tslnr_conv_model

`default_nettype wire

// ===== bench/tb.sv
/*
 * self-checking bench of tslnr_top: register map, user word lock,
 * limit flags, interrupt, conversion pacing for every rate code.
 * assumes: CYC_PER_MS shrunk to 1 so the longest period is short.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tslnr_params.svh"

module tb;
    import tslnr_pkg::*;
    localparam int CYC = 1;
    logic        clk_sys   = 1'b0;
    logic        reset     = 1'b1;
    tslnr_addr_t reg_addr  = '0;
    tslnr_word_t reg_wdata = '0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    tslnr_val_t  next_res  = '0;
    logic [15:0] reg_rdata;
    tslnr_val_t  temp_result;
    logic        temp_valid;
    logic        conv_start;
    logic        irq;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          per [8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};
    tslnr_word_t d;
    int          n;
    int          m;

    tslnr_top #(.CYC_PER_MS(CYC)) i_tslnr_top (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .temp_result(temp_result), .temp_valid(temp_valid),
        .conv_start(conv_start), .irq(irq));
    tslnr_conv_model i_tslnr_conv_model (.clk_sys(clk_sys), .reset(reset),
        .conv_start(conv_start), .next_res(next_res), .temp_valid(temp_valid),
        .temp_result(temp_result));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input tslnr_word_t got, input tslnr_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle strobes; an idle edge follows so strobes never overlap
    task automatic wr(input tslnr_addr_t a, input tslnr_word_t v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input tslnr_addr_t a, output tslnr_word_t v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        v = reg_rdata;
    endtask : rd

    task automatic rdc(input tslnr_addr_t a, input tslnr_word_t exp);
        tslnr_word_t v;
        rd(a, v);
        chk(v, exp);
    endtask : rdc

    task automatic wait_conv(output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (conv_start !== 1'b1 && c < 70000);
    endtask : wait_conv

    // one conversion returning r, then two edges so irq has landed
    task automatic do_conv(input tslnr_val_t r);
        int k;
        next_res <= r;
        wait_conv(k);
        k = 0;
        while (temp_valid !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (2) @(posedge clk_sys);
    endtask : do_conv

    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // cut a hang short well past the expected run length
    initial begin
        #(90000 * 5);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rdc(5'h01, 16'ha000);
        rdc(5'h02, 16'h7ffc);
        rdc(5'h03, 16'h8000);
        rdc(5'h04, 16'h7ffc);
        rdc(5'h05, 16'h8000);
        for (int i = 0; i < 8; i++) rdc(5'(6 + i), 16'h0000);
        rdc(5'h0f, `TSLNR_SILICON_IDENTITY);
        for (int a = 2; a < 6; a++) begin
            wr(5'(a), 16'hffff);
            rdc(5'(a), 16'hfffc);
        end
        wr(5'h0f, 16'h0000);
        rdc(5'h0f, `TSLNR_SILICON_IDENTITY);
        wr(5'h0e, 16'hffff);
        rdc(5'h0e, 16'h0000);
        // locked write dropped and flagged, then unlock and program all
        wr(5'h06, 16'h1234);
        rdc(5'h06, 16'h0000);
        rd(5'h10, d);
        chk(d & 16'h0008, 16'h0008);
        wr(5'h00, 16'h0001);
        for (int i = 0; i < 8; i++) wr(5'(6 + i), 16'h1110 + 16'(i));
        for (int i = 0; i < 8; i++) rdc(5'(6 + i), 16'h1110 + 16'(i));
        wr(5'h00, 16'h0000);
        wr(5'h07, 16'hdead);
        rdc(5'h07, 16'h1111);
        // rate 0, fn1 window, fn2 threshold with hysteresis
        wr(5'h01, 16'h0800);
        wr(5'h02, 16'h0100);
        wr(5'h03, 16'hff00);
        wr(5'h04, 16'h0100);
        wr(5'h05, 16'h0080);
        do_conv(14'h0050);
        rdc(5'h01, 16'h08a0);
        rdc(5'h01, 16'h0820);
        do_conv(14'h0030);
        rdc(5'h01, 16'h0820);
        do_conv(14'h3f00);
        rdc(5'h01, 16'h0840);
        rdc(5'h00, 16'hfc00);
        // interrupt raised, cleared, then masked
        wr(5'h11, 16'h000f);
        wr(5'h12, 16'h0001);
        do_conv(14'h0030);
        chk({15'h0, irq}, 16'h0001);
        wr(5'h11, 16'h0001);
        @(posedge clk_sys);
        chk({15'h0, irq}, 16'h0000);
        wr(5'h12, 16'h0000);
        do_conv(14'h0030);
        chk({15'h0, irq}, 16'h0000);
        rd(5'h10, d);
        chk(d & 16'h0001, 16'h0001);
        // every rate code; a new code waits for the next start
        for (int k = 0; k < 8; k++) begin
            wr(5'h01, {3'(k), 13'h0800});
            wait_conv(m);
            wait_conv(n);
            chk(16'(n), 16'(per[k] * CYC));
            if (k > 0) chk({15'h0, m <= per[k - 1] * CYC}, 16'h0001);
        end
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
